// [common/ldc_defs.svh]
// Register map, field constants and timing figures for the delay channel
// Notes on behaviour
// - Memory sample times feedback gain is added into each written sample.
// - Feedback gain spans zero to one hundred ten percent of unity.
// - At exactly unity gain the recirculated sample is rewritten unchanged.
// - Gain above unity amplifies the recirculated sample before writing.
// - Knob plus positive CV, negative CV dropped, clamped at 110 percent.
// - Knob at zero and CV at or above five volts gives exactly unity.
// - Output blends dry input with wet; send output ignores the blend.
// - Freeze button release toggles freeze; an indicator shows freeze state.
// - Freeze off: record continuously, play back after the delay time.
// - Freeze on: no memory writes; stored memory replays as a loop.
// - Entering freeze: read pointer becomes loop start, write pointer end.
// - Loop length during freeze equals the delay time from time setting.
// - Reverse inverts stepping of both read and write pointers.
// - Reverse button release toggles, cancelled if a knob moved meanwhile.
// - Reverse trigger rising edge toggles reverse; source gives clean edges.
// - Reverse toggle with freeze off swaps read and write positions.
// - Reverse toggle crossfades old and new direction playback.
// - Reverse in freeze plays backwards, loop start re-anchored to toggle.
// - Loop clock per channel plus master clock synced to beat.
// - Loop indicator blinks with equal on and off times.
// - Clock output edges fall on sample clock boundaries.
// - Trigger mode gives 22 ms pulses, square when fast; gate mode option.
// - In freeze the loop clock goes high at each loop start.
// - Beat period is the interval between the two latest tap pulses.
`ifndef LDC_DEFS_SVH
`define LDC_DEFS_SVH
`define LDC_REG_CTRL   8'h00
`define LDC_REG_FB     8'h04
`define LDC_REG_FEED   8'h08
`define LDC_REG_MIX    8'h0C
`define LDC_REG_TIME   8'h10
`define LDC_REG_STATUS 8'h14
`define LDC_REG_BEAT   8'h18
`define LDC_REG_LOOP   8'h1C
`define LDC_REG_GAIN   8'h20
`define LDC_FB_RST     8'h00
`define LDC_FEED_RST   8'hFF
`define LDC_MIX_RST    8'h80
`define LDC_TIME_RST   5'h01
`define LDC_BEAT_RST   18'h04B00
`define LDC_GAIN_UNITY 8'h80
`define LDC_GAIN_MAX   8'h8D
`define LDC_CV_5V      7'h40
`define LDC_GAIN_SH    7
`define LDC_MIX_FULL   9'h100
`define LDC_MIX_SH     8
`define LDC_XF_LEN     7'h40
`define LDC_XF_SH      6
`define LDC_TRIG_MS    22
`define LDC_SMP_MAX    16'sh7FFF
`define LDC_SMP_MIN    16'sh8000
`endif

// [common/ldc_pkg.sv]
// Shared types for the delay channel
package ldc_pkg;
    typedef logic signed [15:0] ldc_smp_t;
    typedef logic [7:0]         ldc_lvl_t;
endpackage

// [logic/ldc_feedback.sv]
// Feedback gain combiner and saturating write-back sum
`timescale 1ns/100ps
`include "ldc_defs.svh"
module ldc_feedback (
    input  ldc_pkg::ldc_lvl_t  knob_i,
    input  logic signed [7:0]  cv_i,
    input  ldc_pkg::ldc_smp_t  mem_i,
    input  logic signed [17:0] add_i,
    output ldc_pkg::ldc_lvl_t  gain_o,
    output ldc_pkg::ldc_smp_t  wr_o
);
    import ldc_pkg::*;
    logic [6:0]         cv_pos;
    logic [8:0]         sum;
    logic signed [24:0] prod;
    logic signed [19:0] total;
    ldc_smp_t           mem_g;

    assign cv_pos = cv_i[7] ? 7'h00 : cv_i[6:0];
    assign sum    = {1'b0, knob_i} + {1'b0, cv_pos, 1'b0};
    always_comb begin
        if (knob_i == 8'h00 && cv_pos >= `LDC_CV_5V) begin
            gain_o = `LDC_GAIN_UNITY;
        end else if (sum > {1'b0, `LDC_GAIN_MAX}) begin
            gain_o = `LDC_GAIN_MAX;
        end else begin
            gain_o = sum[7:0];
        end
    end
    // Unity is 2^7 so the scaled sample is exact at unity
    // Zero gain drops the memory term, so unwritten cells never leak in
    assign mem_g = (gain_o == 8'h00) ? 16'sh0000 : mem_i;
    assign prod  = mem_g * $signed({1'b0, gain_o});
    assign total = 20'(prod >>> `LDC_GAIN_SH) + 20'(add_i);
    always_comb begin
        if (total > 20'(`LDC_SMP_MAX)) begin
            wr_o = `LDC_SMP_MAX;
        end else if (total < 20'(`LDC_SMP_MIN)) begin
            wr_o = `LDC_SMP_MIN;
        end else begin
            wr_o = total[15:0];
        end
    end
endmodule

// [logic/ldc_clkgen.sv]
// Clock output shaper: trigger, square or gate pulse plus even LED
`timescale 1ns/100ps
`include "ldc_defs.svh"
module ldc_clkgen #(
    parameter int BW        = 18,
    parameter int SAMPLE_HZ = 48000
) (
    input  logic          clk_i,
    input  logic          rst_i,
    input  logic          stb_i,
    input  logic          tick_i,
    input  logic [BW-1:0] period_i,
    input  logic          gate_i,
    output logic          out_o,
    output logic          led_o
);
    localparam int TRIG_N = `LDC_TRIG_MS * SAMPLE_HZ / 1000;
    localparam logic [BW-1:0] TRIG_W = BW'(TRIG_N);
    logic [BW-1:0] cnt_reg;
    logic [BW-1:0] cnt_next;
    logic [BW-1:0] half;
    logic [BW-1:0] width;
    logic          pend_reg;

    assign half     = period_i >> 1;
    assign cnt_next = pend_reg ? '0 : cnt_reg + BW'(cnt_reg != '1);
    // Short periods cannot fit the trigger, so fall back to a square
    assign width = (gate_i || half < TRIG_W) ? half : TRIG_W;

    // Tick waits for the next sample so edges stay sample aligned
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pend_reg <= 1'b0;
        end else if (tick_i) begin
            pend_reg <= 1'b1;
        end else if (stb_i) begin
            pend_reg <= 1'b0;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
            out_o   <= 1'b0;
            led_o   <= 1'b0;
        end else if (stb_i) begin
            cnt_reg <= cnt_next;
            out_o   <= cnt_next < width;
            led_o   <= cnt_next < half;
        end
    end
endmodule

// [logic/ldc_channel.sv]
// One looping delay channel with Wishbone register slave
`timescale 1ns/100ps
`include "ldc_defs.svh"
module ldc_channel #(
    parameter int AW        = 12,
    parameter int BW        = 18,
    parameter int SAMPLE_HZ = 48000
) (
    input  logic               clk_i,
    input  logic               rst_i,
    input  logic               wb_cyc_i,
    input  logic               wb_stb_i,
    input  logic               wb_we_i,
    input  logic [7:0]         wb_adr_i,
    input  logic [3:0]         wb_sel_i,
    input  logic [31:0]        wb_dat_i,
    output logic [31:0]        wb_dat_o,
    output logic               wb_ack_o,
    input  logic               sample_stb_i,
    input  ldc_pkg::ldc_smp_t  audio_in_i,
    input  ldc_pkg::ldc_smp_t  return_i,
    input  logic signed [7:0]  fb_cv_i,
    input  logic               beat_tap_i,
    input  logic               freeze_btn_i,
    input  logic               rev_btn_i,
    input  logic               knob_moved_i,
    input  logic               rev_trig_i,
    output ldc_pkg::ldc_smp_t  out_o,
    output ldc_pkg::ldc_smp_t  send_o,
    output logic               out_stb_o,
    output logic               freeze_led_o,
    output logic               loop_clk_o,
    output logic               loop_led_o,
    output logic               beat_clk_o,
    output logic               beat_led_o
);
    import ldc_pkg::*;
    localparam int DEPTH = 1 << AW;
    localparam logic [BW+4:0] LEN_MAX = (BW+5)'(DEPTH - 1);

    logic          wb_ack_reg;
    logic [31:0]   wb_dat_reg;
    logic          wb_hit;
    logic          wb_wr;
    logic          gate_reg;
    ldc_lvl_t      fb_knob_reg;
    ldc_lvl_t      feed_reg;
    ldc_lvl_t      mix_reg;
    logic [4:0]    time_reg;
    logic          freeze_reg;
    logic          rev_reg;
    logic          frz_btn_d;
    logic          rev_btn_d;
    logic          trig_d;
    logic          tap_d;
    logic          knob_seen_reg;
    logic          frz_rel;
    logic          rev_rel;
    logic          rev_tog;
    logic          tap_rise;
    logic [BW-1:0] beat_reg;
    logic [BW-1:0] mcnt_reg;
    logic [BW-1:0] bph_reg;
    logic          beat_tick;
    logic [BW+4:0] len_prod;
    logic [AW-1:0] len_w;
    logic [AW-1:0] wr_reg;
    logic [AW-1:0] start_reg;
    logic [AW-1:0] end_reg;
    logic [AW-1:0] pos_reg;
    logic [AW-1:0] old_rd_reg;
    logic [AW-1:0] rd_w;
    logic          loop_tick;
    logic [6:0]    xf_reg;
    logic          xf_act;
    ldc_smp_t      mem [0:DEPTH-1];
    ldc_smp_t      mem_rd;
    ldc_smp_t      mem_old;
    ldc_smp_t      wet_w;
    ldc_smp_t      wr_smp;
    ldc_lvl_t      fb_gain;
    logic          mem_we;
    logic signed [24:0] in_prod;
    logic signed [17:0] add_w;
    logic [7:0]         w_new;
    logic [7:0]         w_old;
    logic signed [24:0] xsum;
    logic [8:0]         dmix;
    logic signed [26:0] msum;

    // Register slave: one wait state, ack drops the cycle after
    assign wb_hit   = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
    assign wb_wr    = wb_hit & wb_we_i & wb_sel_i[0];
    assign wb_ack_o = wb_ack_reg;
    assign wb_dat_o = wb_dat_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_reg <= 1'b0;
        end else begin
            wb_ack_reg <= wb_hit;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gate_reg    <= 1'b0;
            fb_knob_reg <= `LDC_FB_RST;
            feed_reg    <= `LDC_FEED_RST;
            mix_reg     <= `LDC_MIX_RST;
            time_reg    <= `LDC_TIME_RST;
        end else if (wb_wr) begin
            unique case (wb_adr_i)
                `LDC_REG_CTRL: gate_reg    <= wb_dat_i[0];
                `LDC_REG_FB:   fb_knob_reg <= wb_dat_i[7:0];
                `LDC_REG_FEED: feed_reg    <= wb_dat_i[7:0];
                `LDC_REG_MIX:  mix_reg     <= wb_dat_i[7:0];
                `LDC_REG_TIME: time_reg    <= wb_dat_i[4:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_reg <= 32'h0000_0000;
        end else if (wb_hit && !wb_we_i) begin
            unique case (wb_adr_i)
                `LDC_REG_CTRL:   wb_dat_reg <= 32'(gate_reg);
                `LDC_REG_FB:     wb_dat_reg <= 32'(fb_knob_reg);
                `LDC_REG_FEED:   wb_dat_reg <= 32'(feed_reg);
                `LDC_REG_MIX:    wb_dat_reg <= 32'(mix_reg);
                `LDC_REG_TIME:   wb_dat_reg <= 32'(time_reg);
                `LDC_REG_STATUS: wb_dat_reg <=
                    32'({xf_act, loop_led_o, rev_reg, freeze_reg});
                `LDC_REG_BEAT:   wb_dat_reg <= 32'(beat_reg);
                `LDC_REG_LOOP:   wb_dat_reg <=
                    {16'(end_reg), 16'(start_reg)};
                `LDC_REG_GAIN:   wb_dat_reg <= 32'(fb_gain);
                default:         wb_dat_reg <= 32'h0000_0000;
            endcase
        end
    end

    // Buttons act on release; a knob turn while held cancels reverse
    assign frz_rel  = frz_btn_d & ~freeze_btn_i;
    assign rev_rel  = rev_btn_d & ~rev_btn_i & ~knob_seen_reg
                      & ~knob_moved_i;
    assign rev_tog  = rev_rel | (rev_trig_i & ~trig_d);
    assign tap_rise = beat_tap_i & ~tap_d;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frz_btn_d     <= 1'b0;
            rev_btn_d     <= 1'b0;
            trig_d        <= 1'b0;
            tap_d         <= 1'b0;
            knob_seen_reg <= 1'b0;
        end else begin
            frz_btn_d     <= freeze_btn_i;
            rev_btn_d     <= rev_btn_i;
            trig_d        <= rev_trig_i;
            tap_d         <= beat_tap_i;
            knob_seen_reg <= rev_btn_i & (knob_seen_reg | knob_moved_i);
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            freeze_reg <= 1'b0;
            rev_reg    <= 1'b0;
        end else begin
            freeze_reg <= freeze_reg ^ frz_rel;
            rev_reg    <= rev_reg ^ rev_tog;
        end
    end
    assign freeze_led_o = freeze_reg;

    // Beat period from tap spacing, counted in samples
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            beat_reg <= `LDC_BEAT_RST;
            mcnt_reg <= '0;
        end else if (tap_rise) begin
            mcnt_reg <= '0;
            if (mcnt_reg != '0) begin
                beat_reg <= mcnt_reg;
            end
        end else if (sample_stb_i && mcnt_reg != '1) begin
            mcnt_reg <= mcnt_reg + 1'b1;
        end
    end
    assign beat_tick = tap_rise
                       | (sample_stb_i & (bph_reg >= beat_reg - 1'b1));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bph_reg <= '0;
        end else if (beat_tick) begin
            bph_reg <= '0;
        end else if (sample_stb_i) begin
            bph_reg <= bph_reg + 1'b1;
        end
    end

    // Delay time is beats times multiplier, limited to the memory
    assign len_prod = beat_reg * time_reg;
    always_comb begin
        if (len_prod > LEN_MAX) begin
            len_w = AW'(LEN_MAX);
        end else if (len_prod == '0) begin
            len_w = AW'(1);
        end else begin
            len_w = len_prod[AW-1:0];
        end
    end

    // Read pointer trails the write pointer, ahead of it when reversed
    always_comb begin
        if (freeze_reg) begin
            rd_w = rev_reg ? start_reg - pos_reg
                           : start_reg + pos_reg;
        end else begin
            rd_w = rev_reg ? wr_reg + len_w : wr_reg - len_w;
        end
    end
    assign loop_tick = (frz_rel & ~freeze_reg) | (rev_tog & freeze_reg)
                       | (sample_stb_i & (pos_reg >= len_w - 1'b1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_reg    <= '0;
            start_reg <= '0;
            end_reg   <= '0;
            pos_reg   <= '0;
        end else if (frz_rel && !freeze_reg) begin
            start_reg <= rd_w;
            end_reg   <= wr_reg;
            pos_reg   <= '0;
        end else if (rev_tog && freeze_reg) begin
            start_reg <= rd_w;
            pos_reg   <= '0;
        end else if (rev_tog) begin
            // Reader takes the writer's place under the new direction
            wr_reg <= rd_w;
        end else if (sample_stb_i) begin
            if (!freeze_reg) begin
                wr_reg <= rev_reg ? wr_reg - 1'b1 : wr_reg + 1'b1;
            end
            pos_reg <= loop_tick ? '0 : pos_reg + 1'b1;
        end
    end

    // Crossfade: old reader keeps going in the old direction
    assign xf_act = xf_reg < `LDC_XF_LEN;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xf_reg     <= `LDC_XF_LEN;
            old_rd_reg <= '0;
        end else if (rev_tog) begin
            xf_reg     <= 7'h00;
            old_rd_reg <= rd_w;
        end else if (sample_stb_i && xf_act) begin
            xf_reg     <= xf_reg + 1'b1;
            old_rd_reg <= rev_reg ? old_rd_reg + 1'b1 : old_rd_reg - 1'b1;
        end
    end

    // Datapath, one sample per strobe
    assign mem_rd  = mem[rd_w];
    assign mem_old = mem[old_rd_reg];
    assign w_new   = {1'b0, xf_reg};
    assign w_old   = {1'b0, `LDC_XF_LEN} - w_new;
    assign xsum    = 25'(mem_rd * $signed({1'b0, w_new}))
                     + 25'(mem_old * $signed({1'b0, w_old}));
    assign wet_w   = xf_act ? 16'(xsum >>> `LDC_XF_SH) : mem_rd;
    assign in_prod = audio_in_i * $signed({1'b0, feed_reg});
    assign add_w   = 18'(in_prod >>> `LDC_MIX_SH) + 18'(return_i);
    assign mem_we  = sample_stb_i & ~freeze_reg;

    ldc_feedback u_fb (
        .knob_i (fb_knob_reg),
        .cv_i   (fb_cv_i),
        .mem_i  (mem_rd),
        .add_i  (add_w),
        .gain_o (fb_gain),
        .wr_o   (wr_smp)
    );

    // Memory itself is not reset; stale audio is harmless
    always_ff @(posedge clk_i) begin
        if (mem_we) begin
            mem[wr_reg] <= wr_smp;
        end
    end

    // Dry comes straight from the input, ahead of record level
    assign dmix = `LDC_MIX_FULL - {1'b0, mix_reg};
    assign msum = 27'(audio_in_i * $signed({1'b0, dmix}))
                  + 27'(wet_w * $signed({1'b0, mix_reg}));
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_o     <= '0;
            send_o    <= '0;
            out_stb_o <= 1'b0;
        end else begin
            out_stb_o <= sample_stb_i;
            if (sample_stb_i) begin
                out_o  <= 16'(msum >>> `LDC_MIX_SH);
                send_o <= wet_w;
            end
        end
    end

    ldc_clkgen #(.BW(BW), .SAMPLE_HZ(SAMPLE_HZ)) u_loop_clk (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .stb_i    (sample_stb_i),
        .tick_i   (loop_tick),
        .period_i (BW'(len_w)),
        .gate_i   (gate_reg),
        .out_o    (loop_clk_o),
        .led_o    (loop_led_o)
    );
    ldc_clkgen #(.BW(BW), .SAMPLE_HZ(SAMPLE_HZ)) u_beat_clk (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .stb_i    (sample_stb_i),
        .tick_i   (beat_tick),
        .period_i (beat_reg),
        .gate_i   (gate_reg),
        .out_o    (beat_clk_o),
        .led_o    (beat_led_o)
    );

    sequence s_rev_knob;
        rev_btn_i && knob_moved_i;
    endsequence
    sequence s_rev_let_go;
        !rev_btn_i && !rev_trig_i;
    endsequence
    property p_freeze_tog;
        @(posedge clk_i) disable iff (rst_i)
        $fell(freeze_btn_i) |=> freeze_led_o != $past(freeze_led_o);
    endproperty
    a_freeze_tog: assert property (p_freeze_tog)
        else $error("freeze did not toggle on release");
    property p_no_write;
        @(posedge clk_i) disable iff (rst_i) freeze_reg |-> !mem_we;
    endproperty
    a_no_write: assert property (p_no_write)
        else $error("memory written during freeze");
    property p_loop_anchor;
        @(posedge clk_i) disable iff (rst_i)
        $rose(freeze_reg) |-> start_reg == $past(rd_w)
                              && end_reg == $past(wr_reg);
    endproperty
    a_loop_anchor: assert property (p_loop_anchor)
        else $error("loop points not taken from pointers");
    property p_gain_clamp;
        @(posedge clk_i) disable iff (rst_i) fb_gain <= `LDC_GAIN_MAX;
    endproperty
    a_gain_clamp: assert property (p_gain_clamp)
        else $error("feedback gain above ceiling");
    property p_gain_unity;
        @(posedge clk_i) disable iff (rst_i)
        fb_knob_reg == 8'h00 && !fb_cv_i[7] && fb_cv_i[6:0] >= `LDC_CV_5V
        |-> fb_gain == `LDC_GAIN_UNITY;
    endproperty
    a_gain_unity: assert property (p_gain_unity)
        else $error("full CV with knob at zero is not unity");
    property p_rev_cancel;
        @(posedge clk_i) disable iff (rst_i)
        s_rev_knob ##1 s_rev_let_go |=> rev_reg == $past(rev_reg);
    endproperty
    a_rev_cancel: assert property (p_rev_cancel)
        else $error("reverse toggled after knob moved");
    property p_trig_tog;
        @(posedge clk_i) disable iff (rst_i)
        $rose(rev_trig_i) && !rev_rel |=> rev_reg != $past(rev_reg);
    endproperty
    a_trig_tog: assert property (p_trig_tog)
        else $error("reverse trigger edge missed");
    property p_swap;
        @(posedge clk_i) disable iff (rst_i)
        rev_tog && !freeze_reg && !frz_rel
        |=> wr_reg == $past(rd_w) ##0 rd_w == $past(wr_reg);
    endproperty
    a_swap: assert property (p_swap)
        else $error("pointers not swapped on reverse");
    property p_beat_meas;
        @(posedge clk_i) disable iff (rst_i)
        tap_rise && mcnt_reg != '0 |=> beat_reg == $past(mcnt_reg);
    endproperty
    a_beat_meas: assert property (p_beat_meas)
        else $error("beat period not latched on tap");
endmodule

// [dv/ldc_src_model.sv]
// Converter model: sample strobes, steady input and return samples
`timescale 1ns/100ps
module ldc_src_model #(
    parameter int DIV = 4
) (
    input  logic              clk_i,
    output ldc_pkg::ldc_smp_t audio_o,
    output ldc_pkg::ldc_smp_t return_o,
    output logic              stb_o
);
    import ldc_pkg::*;
    int cnt = 0;
    initial begin
        stb_o    = 1'b0;
        audio_o  = 16'sh1234;
        return_o = 16'sh0000;
    end
    // Strobes kept DIV clk apart, never closer than the stream allows
    always @(posedge clk_i) begin
        cnt   <= (cnt == DIV - 1) ? 0 : cnt + 1;
        stb_o <= (cnt == 0);
    end
endmodule

// [dv/testbench.sv]
// Self-checking bench for one looping delay channel
`timescale 1ns/100ps
module testbench;
    import ldc_pkg::*;
    typedef struct {
        logic        we;
        logic [7:0]  adr;
        logic [31:0] dat;
        logic [7:0]  cv;
        logic [31:0] exp;
    } ldc_row_t;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [7:0]  adr   = 8'h00;
    logic [31:0] dat   = 32'h0;
    logic [31:0] q;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic [7:0]  cv    = 8'h00;
    logic        frz   = 1'b0;
    logic        rev   = 1'b0;
    logic        trg   = 1'b0;
    logic        knob  = 1'b0;
    logic        beat  = 1'b0;
    logic        bclk;
    logic        bled;
    logic        s_stb;
    logic        out_stb_o;
    logic        freeze_led_o;
    ldc_smp_t    a_in;
    ldc_smp_t    a_ret;
    ldc_smp_t    out_o;
    ldc_smp_t    send_o;
    int          err_count = 0;
    int          cmp_count = 0;
    int          ticks     = 0;
    int          hi_clk    = 0;
    int          hi_led    = 0;
    // Reset values first, then the 5 V unity point, gain sums and clamps
    ldc_row_t rows [21] = '{
        '{1'b0, 8'h00, 32'h0, 8'h00, 32'h0},
        '{1'b0, 8'h04, 32'h0, 8'h00, 32'h0},
        '{1'b0, 8'h08, 32'h0, 8'h00, 32'hFF},
        '{1'b0, 8'h0C, 32'h0, 8'h00, 32'h80},
        '{1'b0, 8'h10, 32'h0, 8'h00, 32'h1},
        '{1'b0, 8'h14, 32'h0, 8'h00, 32'h4},
        '{1'b0, 8'h18, 32'h0, 8'h00, 32'h4B00},
        '{1'b0, 8'h20, 32'h0, 8'h00, 32'h0},
        '{1'b1, 8'h40, 32'hFF, 8'h00, 32'h0},
        '{1'b0, 8'h40, 32'h0, 8'h00, 32'h0},
        '{1'b1, 8'h04, 32'h0, 8'h00, 32'h0},
        '{1'b0, 8'h20, 32'h0, 8'h40, 32'h80},
        '{1'b0, 8'h20, 32'h0, 8'h7F, 32'h80},
        '{1'b0, 8'h20, 32'h0, 8'h3F, 32'h7E},
        '{1'b1, 8'h04, 32'h20, 8'h00, 32'h0},
        '{1'b0, 8'h20, 32'h0, 8'h10, 32'h40},
        '{1'b0, 8'h20, 32'h0, 8'hF0, 32'h20},
        '{1'b1, 8'h04, 32'h80, 8'h00, 32'h0},
        '{1'b0, 8'h20, 32'h0, 8'h7F, 32'h8D},
        '{1'b1, 8'h00, 32'h1, 8'h00, 32'h0},
        '{1'b0, 8'h00, 32'h0, 8'h00, 32'h1}
    };

    always #12.5 clk_i = ~clk_i;

    ldc_src_model #(.DIV(4)) src (.clk_i(clk_i), .audio_o(a_in),
        .return_o(a_ret), .stb_o(s_stb));

    // Small address width keeps the delay short enough to hear back
    ldc_channel #(.AW(6), .BW(18), .SAMPLE_HZ(48000)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_stb_i(s_stb),
        .audio_in_i(a_in), .return_i(a_ret), .fb_cv_i(cv),
        .beat_tap_i(beat), .freeze_btn_i(frz), .rev_btn_i(rev),
        .knob_moved_i(knob), .rev_trig_i(trg), .out_o(out_o),
        .send_o(send_o), .out_stb_o(out_stb_o),
        .freeze_led_o(freeze_led_o), .loop_clk_o(), .loop_led_o(),
        .beat_clk_o(bclk), .beat_led_o(bled));

    task automatic chk(input string nm, input logic [31:0] g, e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) err_count++;
    endtask

    // Press and release; k: 0 freeze, 1 reverse, 2 trigger, 3 reverse+knob
    task automatic tap(input int k);
        @(posedge clk_i);
        frz  <= (k == 0);
        rev  <= (k == 1 || k == 3);
        trg  <= (k == 2);
        knob <= (k == 3);
        repeat (3) @(posedge clk_i);
        frz  <= 1'b0;
        rev  <= 1'b0;
        trg  <= 1'b0;
        knob <= 1'b0;
        repeat (4) @(posedge clk_i);
        wb(1'b0, 8'h14, 32'h0);
    endtask

    task automatic next_out();
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (out_stb_o !== 1'b1 && n < 10);
    endtask

    task automatic give_verdict();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 5000) begin
            err_count++;
            give_verdict();
        end
    end

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            cv <= rows[i].cv;
            repeat (8) @(posedge clk_i);
            wb(rows[i].we, rows[i].adr, rows[i].dat);
            if (!rows[i].we) chk("reg", q, rows[i].exp);
        end
        $display("Register table done");
        cv <= 8'h00;
        wb(1'b1, 8'h04, 32'h0);
        wb(1'b1, 8'h0C, 32'h0);
        repeat (400) @(posedge clk_i);
        next_out();
        chk("dry", 32'(out_o), 32'(a_in));
        chk("wet", 32'(send_o), 32'(16'sh1221));
        $display("Record and mix done");
        tap(0);
        chk("frz", q[0], 1'b1);
        chk("led", freeze_led_o, 1'b1);
        wb(1'b1, 8'h08, 32'h0);
        repeat (400) @(posedge clk_i);
        next_out();
        chk("hold", 32'(send_o), 32'(16'sh1221));
        $display("Freeze done");
        tap(3);
        chk("rev_cancel", q[1], 1'b0);
        tap(1);
        chk("rev_btn", q[1], 1'b1);
        tap(2);
        chk("rev_trig", q[1], 1'b0);
        tap(0);
        chk("frz_off", q[0], 1'b0);
        // Let the earlier crossfade run out first
        repeat (300) @(posedge clk_i);
        tap(1);
        chk("rev_run", q[1], 1'b1);
        chk("xfade", q[3], 1'b1);
        $display("Reverse controls done");
        // Clean tap pulses 40 clk apart, aligned to a strobe: 10 samples
        do begin
            @(posedge clk_i);
        end while (s_stb !== 1'b1);
        beat <= 1'b1;
        repeat (2) @(posedge clk_i);
        beat <= 1'b0;
        repeat (38) @(posedge clk_i);
        beat <= 1'b1;
        repeat (2) @(posedge clk_i);
        beat <= 1'b0;
        wb(1'b0, 8'h18, 32'h0);
        chk("beat", q, 32'hA);
        repeat (12) @(posedge clk_i);
        repeat (40) begin
            @(posedge clk_i);
            if (bclk === 1'b1) hi_clk++;
            if (bled === 1'b1) hi_led++;
        end
        chk("beat_clk", hi_clk, 20);
        chk("beat_led", hi_led, 20);
        $display("Beat clock done");
        give_verdict();
    end
endmodule
